// ---- hdl/lbc_pkg.sv ----
// Shared constants and types for the local bus cycle engine
package lbc_pkg;
  // Clock and quarter-phase timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned QUARTER_NS = 100;
  localparam int unsigned QUARTER_CLKS = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus widths
  localparam int unsigned BUS_W = 16;
  localparam int unsigned PAR_W = BUS_W / 8;
  // Quarter phase numbers
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  // Status codes as {instr_data_status, read_write_status}
  localparam logic [1:0] STAT_DATA_WRITE = 2'h0;
  localparam logic [1:0] STAT_DATA_READ = 2'h1;
  localparam logic [1:0] STAT_INVALID = 2'h2;
  localparam logic [1:0] STAT_INSTR_OPERAND = 2'h3;
  localparam logic [1:0] STAT_RST = STAT_DATA_WRITE;
  // Memory map
  localparam logic [15:0] EXP_LO = 16'h1000;
  localparam logic [15:0] EXP_HI = 16'hBFFE;
  localparam int unsigned TOP_BIT = 15;
  // Parity sense: one means odd parity per byte
  localparam logic PARITY_ODD = 1'b1;
  // Bus cycle states, Gray along idle, address, data, wait
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_DATA = 2'h3,
    ST_WAIT = 2'h2
  } lbc_state_t;
endpackage : lbc_pkg

// ---- hdl/lbc_phase_if.sv ----
// Quarter-phase timing carried from the phase generator to the cycle engine
`timescale 1ns/1ps
`default_nettype none
interface lbc_phase_if;
  logic [1:0] quarter;
  logic first;
  logic last;
  modport src (output quarter, output first, output last);
  modport sink (input quarter, input first, input last);
endinterface : lbc_phase_if
`default_nettype wire

// ---- hdl/lbc_phase_gen.sv ----
// Divider that splits each bus period into four quarters
`timescale 1ns/1ps
`default_nettype none
module lbc_phase_gen #(
  parameter int unsigned QUARTER_CLKS = lbc_pkg::QUARTER_CLKS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Phase outputs
  lbc_phase_if.src ph
);
  import lbc_pkg::*;

  localparam int unsigned SUB_W = (QUARTER_CLKS > 1) ? $clog2(QUARTER_CLKS) : 1;
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(QUARTER_CLKS - 1);

  logic [SUB_W-1:0] sub_q;
  logic [1:0] quarter_q;

  // Sub-quarter counter is the one-cycle enable for quarter steps
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sub_q <= '0;
    end
    else if (sub_q == SUB_LAST)
    begin
      sub_q <= '0;
    end
    else
    begin
      sub_q <= sub_q + 1'b1;
    end
  end

  // Quarter counter wraps Q4 back to Q1
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      quarter_q <= PH_Q1;
    end
    else if (sub_q == SUB_LAST)
    begin
      quarter_q <= quarter_q + 2'h1;
    end
  end

  // Phase seen by the cycle engine; its pins lag this by one clock
  assign ph.quarter = quarter_q;
  assign ph.first = (sub_q == '0);
  assign ph.last = (sub_q == SUB_LAST);
endmodule : lbc_phase_gen
`default_nettype wire

// ---- hdl/lbc_bus_master.sv ----
// Local bus cycle engine of the communications processor, acting as master
// Function
// - Write cycle asserts data enable at Q3 start and drives write data.
// - Data enable held past clock one fall, released within Q1.
// - Every cycle lasts one bus period, lengthened by whole wait periods.
// - Master or slave may pull ready low to stretch a cycle.
// - Processor samples ready as input, as master or as slave.
// - Handler honours waits as slave and ignores them as master.
// - Data source keeps driving its data while ready is low.
// - During waits the machine holds; no interrupt or bus grant is served.
// - Status lines encode data write, data read, invalid, instruction fetch.
// - Data write code is shown on data writes and during reset.
// - Data read code is shown on data reads.
// - Internal RAM accesses still show status and address on the bus.
// - Instruction or immediate operand fetches show the instruction code.
// - Bus spans 64K bytes; 1000 through BFFE is expansion memory.
// - Each byte on the bus carries a parity bit stored and returned.
// - Top address bit is driven high on memory cycles.
// - Cycle start makes status valid and puts address out with latch pulse.
// - Ready sampled at Q4 start; high ends the cycle, low continues it.
`timescale 1ns/1ps
`default_nettype none
module lbc_bus_master #(
  parameter int unsigned QUARTER_CLKS = lbc_pkg::QUARTER_CLKS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Request side
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_instr_in,
  input wire logic req_internal_in,
  input wire logic [lbc_pkg::BUS_W-1:0] req_addr_in,
  input wire logic [lbc_pkg::BUS_W-1:0] req_wdata_in,
  output logic req_taken_out,
  output logic rsp_valid_out,
  output logic [lbc_pkg::BUS_W-1:0] rsp_rdata_out,
  output logic rsp_parity_err_out,
  // Role, arbitration and status
  input wire logic role_handler_in,
  input wire logic slave_selected_in,
  input wire logic stretch_in,
  input wire logic bus_req_in,
  input wire logic intr_req_in,
  output logic bus_grant_out,
  output logic intr_ack_out,
  output logic slave_hold_out,
  output logic ready_low_out,
  output logic cycle_wait_out,
  output logic addr_in_expansion_out,
  // Bus timing and status pins
  output logic phase_clock_one_out,
  output logic phase_clock_two_out,
  output logic address_latch_pulse_out,
  output logic data_enable_n_out,
  output logic instr_data_status_out,
  output logic read_write_status_out,
  // Multiplexed address/data and parity pins
  input wire logic [lbc_pkg::BUS_W-1:0] muxed_addr_data_in,
  output logic [lbc_pkg::BUS_W-1:0] muxed_addr_data_out,
  output logic muxed_addr_data_oe_out,
  input wire logic [lbc_pkg::PAR_W-1:0] muxed_parity_in,
  output logic [lbc_pkg::PAR_W-1:0] muxed_parity_out,
  // Open-drain ready pin
  input wire logic local_ready_n_in,
  output logic local_ready_n_out,
  output logic local_ready_n_oe_out
);
  import lbc_pkg::*;

  lbc_phase_if ph ();

  lbc_state_t state_q;
  lbc_state_t state_d;
  logic ready_low_q;
  logic wait_now;
  logic cycle_end;
  logic free;
  logic free_end;
  logic take;
  logic in_data;
  logic [BUS_W-1:0] addr_q;
  logic [BUS_W-1:0] wdata_q;
  logic wr_q;
  logic int_q;
  logic [1:0] stat_q;
  logic hold_q;
  logic hold_wr_q;
  logic cap_q;
  logic cap_rd_q;
  logic [BUS_W-1:0] hold_data_q;
  logic [PAR_W-1:0] hold_par_q;
  logic [PAR_W-1:0] wpar;
  logic [PAR_W-1:0] rpar_bad;
  logic taken_q;
  logic rsp_valid_q;
  logic [BUS_W-1:0] rsp_rdata_q;
  logic rsp_err_q;
  logic grant_q;
  logic intr_ack_q;
  logic slave_hold_q;
  logic wait_q;
  logic exp_q;
  logic pclk1_q;
  logic pclk2_q;
  logic ale_q;
  logic den_n_q;
  logic [BUS_W-1:0] mad_q;
  logic mad_oe_q;
  logic [PAR_W-1:0] par_q;
  logic rdy_oe_q;
  logic rdy_out_q;

  // Quarter-phase divider
  lbc_phase_gen #(
    .QUARTER_CLKS(QUARTER_CLKS)
  ) u_phase (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ph(ph)
  );

  // Per-byte parity, generated for writes and checked on reads
  for (genvar b = 0; b < PAR_W; b++)
  begin : g_par
    assign wpar[b] = (^wdata_q[8*b +: 8]) ^ PARITY_ODD;
    assign rpar_bad[b] = (^muxed_addr_data_in[8*b +: 8]) ^ PARITY_ODD ^ muxed_parity_in[b];
  end

  // Cycle bookkeeping terms
  assign in_data = (state_q == ST_DATA) || (state_q == ST_WAIT);
  assign cycle_end = ph.last && (ph.quarter == PH_Q4);
  // Handler as master and internal accesses never stretch
  assign wait_now = ready_low_q && !role_handler_in && !int_q;
  assign free = (state_q == ST_IDLE) || (in_data && !wait_now);
  assign free_end = cycle_end && free;
  assign take = free_end && req_valid_in && !bus_req_in && !grant_q;

  // Ready is sampled at Q4 start every period, in any role
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ready_low_q <= 1'b0;
    end
    else if (ph.first && (ph.quarter == PH_Q4))
    begin
      ready_low_q <= !local_ready_n_in;
    end
  end

  // Next-state logic; quarters only advance at their last clock
  always_comb
  begin
    state_d = state_q;
    if (ph.last)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (take)
          begin
            state_d = ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          if (ph.quarter == PH_Q2)
          begin
            state_d = ST_DATA;
          end
        end
        ST_DATA, ST_WAIT:
        begin
          if (ph.quarter == PH_Q4)
          begin
            if (wait_now)
            begin
              state_d = ST_WAIT;
            end
            else if (take)
            begin
              state_d = ST_ADDR;
            end
            else
            begin
              state_d = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Request capture; fields stay frozen through any wait periods
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      addr_q <= '0;
      wdata_q <= '0;
      wr_q <= 1'b0;
      int_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else if (take)
    begin
      addr_q <= req_addr_in;
      wdata_q <= req_wdata_in;
      wr_q <= req_write_in && !req_instr_in;
      int_q <= req_internal_in;
      exp_q <= (req_addr_in >= EXP_LO) && (req_addr_in <= EXP_HI);
    end
  end

  // Status code changes at the start of Q1, reset shows data write
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stat_q <= STAT_RST;
    end
    else if (take)
    begin
      if (req_instr_in)
      begin
        stat_q <= STAT_INSTR_OPERAND;
      end
      else if (req_write_in)
      begin
        stat_q <= STAT_DATA_WRITE;
      end
      else
      begin
        stat_q <= STAT_DATA_READ;
      end
    end
  end

  // Enable hold into Q1 and read capture at the end of Q4
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hold_q <= 1'b0;
      hold_wr_q <= 1'b0;
      cap_q <= 1'b0;
      cap_rd_q <= 1'b0;
      hold_data_q <= '0;
      hold_par_q <= '0;
    end
    else if (free_end && in_data)
    begin
      // Kept apart from the request fields, which a back-to-back take overwrites here
      hold_q <= !int_q;
      hold_wr_q <= wr_q && !int_q;
      hold_data_q <= wdata_q;
      hold_par_q <= wpar;
      cap_q <= 1'b1;
      cap_rd_q <= !wr_q && !int_q;
    end
    else if (ph.first && (ph.quarter == PH_Q1))
    begin
      hold_q <= 1'b0;
      hold_wr_q <= 1'b0;
      cap_q <= 1'b0;
    end
  end

  // Answer pulses; read data is taken as the pins leave Q4
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      taken_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      rsp_err_q <= 1'b0;
    end
    else
    begin
      taken_q <= take;
      rsp_valid_q <= cap_q && ph.first && (ph.quarter == PH_Q1);
      if (cap_q && ph.first && (ph.quarter == PH_Q1))
      begin
        // Writes and internal accesses return zero, their data is not on the bus
        rsp_rdata_q <= cap_rd_q ? muxed_addr_data_in : '0;
        rsp_err_q <= cap_rd_q && (|rpar_bad);
      end
    end
  end

  // Grants and interrupt service only at a free cycle boundary
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      grant_q <= 1'b0;
      intr_ack_q <= 1'b0;
    end
    else
    begin
      intr_ack_q <= free_end && intr_req_in;
      if (free_end)
      begin
        grant_q <= bus_req_in;
      end
    end
  end

  // Status outputs; slave hold follows the sampled ready while selected
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      slave_hold_q <= 1'b0;
      wait_q <= 1'b0;
    end
    else
    begin
      slave_hold_q <= ready_low_q && slave_selected_in;
      wait_q <= (state_d == ST_WAIT);
    end
  end

  // Phase clocks: one is high in Q3-Q4, two in Q2-Q3
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pclk1_q <= 1'b0;
      pclk2_q <= 1'b0;
    end
    else
    begin
      pclk1_q <= ph.quarter[1];
      pclk2_q <= (ph.quarter == PH_Q2) || (ph.quarter == PH_Q3);
    end
  end

  // Latch pulse covers the first clock of Q2 so it falls with address stable
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ale_q <= 1'b0;
    end
    else
    begin
      ale_q <= (state_q == ST_ADDR) && (ph.quarter == PH_Q2) && ph.first;
    end
  end

  // Data enable: Q3 onward through waits, plus the first clock of next Q1
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      den_n_q <= 1'b1;
    end
    else
    begin
      den_n_q <= !((in_data && !int_q)
        || (hold_q && ph.first && (ph.quarter == PH_Q1)));
    end
  end

  // Multiplexed lines: address in Q2, write data while enabled, else float
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mad_q <= '0;
      mad_oe_q <= 1'b0;
      par_q <= '0;
    end
    else if ((state_q == ST_ADDR) && (ph.quarter == PH_Q2))
    begin
      // Internal accesses show their address as well
      mad_q <= {1'b1, addr_q[TOP_BIT-1:0]};
      mad_oe_q <= 1'b1;
      par_q <= '0;
    end
    else if (in_data && wr_q && !int_q)
    begin
      // Write data and parity stay driven through waits
      mad_q <= wdata_q;
      mad_oe_q <= 1'b1;
      par_q <= wpar;
    end
    else if (hold_wr_q && ph.first && (ph.quarter == PH_Q1))
    begin
      // Hold clock shows the copy, the request data may already be the next cycle's
      mad_q <= hold_data_q;
      mad_oe_q <= 1'b1;
      par_q <= hold_par_q;
    end
    else
    begin
      // Released for reads so the slave may drive under the enable
      mad_q <= '0;
      mad_oe_q <= 1'b0;
      par_q <= '0;
    end
  end

  // Ready pull-down on request while this master is in its data phase
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdy_oe_q <= 1'b0;
      rdy_out_q <= 1'b0;
    end
    else
    begin
      rdy_oe_q <= stretch_in && in_data && !int_q;
      rdy_out_q <= 1'b0;
    end
  end

  // Port assignments, all from flip-flops
  assign req_taken_out = taken_q;
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_rdata_out = rsp_rdata_q;
  assign rsp_parity_err_out = rsp_err_q;
  assign bus_grant_out = grant_q;
  assign intr_ack_out = intr_ack_q;
  assign slave_hold_out = slave_hold_q;
  assign ready_low_out = ready_low_q;
  assign cycle_wait_out = wait_q;
  assign addr_in_expansion_out = exp_q;
  assign phase_clock_one_out = pclk1_q;
  assign phase_clock_two_out = pclk2_q;
  assign address_latch_pulse_out = ale_q;
  assign data_enable_n_out = den_n_q;
  assign instr_data_status_out = stat_q[1];
  assign read_write_status_out = stat_q[0];
  assign muxed_addr_data_out = mad_q;
  assign muxed_addr_data_oe_out = mad_oe_q;
  assign muxed_parity_out = par_q;
  assign local_ready_n_out = rdy_out_q;
  assign local_ready_n_oe_out = rdy_oe_q;
endmodule : lbc_bus_master
`default_nettype wire

// ---- verif/lbc_bus_properties.sv ----
// Concurrent checks on the local bus cycle engine pins
`timescale 1ns/1ps
`default_nettype none
module lbc_bus_properties #(
  parameter int unsigned QUARTER_CLKS = 2
) (
  // Clock, reset and cycle flow
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic role_handler_in,
  input wire logic req_taken_out,
  input wire logic rsp_valid_out,
  input wire logic bus_grant_out,
  input wire logic intr_ack_out,
  input wire logic cycle_wait_out,
  // Bus pins
  input wire logic phase_clock_one_out,
  input wire logic phase_clock_two_out,
  input wire logic address_latch_pulse_out,
  input wire logic data_enable_n_out,
  input wire logic instr_data_status_out,
  input wire logic read_write_status_out,
  input wire logic [lbc_pkg::BUS_W-1:0] muxed_addr_data_out,
  input wire logic muxed_addr_data_oe_out,
  input wire logic [lbc_pkg::PAR_W-1:0] muxed_parity_out
);
  import lbc_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Pin quarters decoded from the two phase clocks
  sequence s_q3;
    phase_clock_one_out && phase_clock_two_out;
  endsequence
  sequence s_q1;
    !phase_clock_one_out && !phase_clock_two_out;
  endsequence
  sequence s_taken;
    req_taken_out;
  endsequence
  a_reset_code:
    assert property ($rose(rst_n_in) |-> !instr_data_status_out && !read_write_status_out)
    else $error("status not data write after reset");
  a_addr_top_bit:
    assert property (address_latch_pulse_out |-> muxed_addr_data_oe_out
      && muxed_addr_data_out[TOP_BIT]) else $error("address phase wrong");
  a_status_valid:
    assert property (address_latch_pulse_out |->
      {instr_data_status_out, read_write_status_out} != STAT_INVALID)
    else $error("invalid status code");
  a_enable_at_q3:
    assert property ($fell(data_enable_n_out) |-> s_q3) else $error("enable not at Q3");
  a_enable_hold:
    assert property ($fell(phase_clock_one_out) && !$past(data_enable_n_out)
      && !cycle_wait_out |-> !data_enable_n_out ##1 data_enable_n_out)
    else $error("enable hold wrong");
  a_release_q1:
    assert property ($rose(data_enable_n_out) |-> s_q1) else $error("enable release not Q1");
  a_write_data_hold:
    assert property (!data_enable_n_out && muxed_addr_data_oe_out
      && $past(!data_enable_n_out && muxed_addr_data_oe_out) |-> $stable(muxed_addr_data_out))
    else $error("write data moved");
  a_read_bus_free:
    assert property (read_write_status_out && phase_clock_one_out && phase_clock_two_out
      |-> !muxed_addr_data_oe_out) else $error("master drives on read");
  a_parity_odd:
    assert property (muxed_addr_data_oe_out && !data_enable_n_out |-> muxed_parity_out
      == {~^muxed_addr_data_out[15:8], ~^muxed_addr_data_out[7:0]})
    else $error("parity wrong");
  a_wait_no_service:
    assert property (cycle_wait_out |-> !intr_ack_out && !$rose(bus_grant_out))
    else $error("served during wait");
  a_handler_no_wait:
    assert property (role_handler_in && $past(role_handler_in) |-> !$rose(cycle_wait_out))
    else $error("handler took a wait");
  a_min_period:
    assert property (rsp_valid_out |=> !rsp_valid_out [*7]) else $error("cycle too short");
  a_cycle_ends:
    assert property (s_taken |-> ##[1:100] rsp_valid_out) else $error("cycle never ended");
endmodule : lbc_bus_properties
bind lbc_bus_master lbc_bus_properties #(.QUARTER_CLKS(QUARTER_CLKS)) props_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .role_handler_in(role_handler_in),
  .req_taken_out(req_taken_out), .rsp_valid_out(rsp_valid_out),
  .bus_grant_out(bus_grant_out), .intr_ack_out(intr_ack_out),
  .cycle_wait_out(cycle_wait_out), .phase_clock_one_out(phase_clock_one_out),
  .phase_clock_two_out(phase_clock_two_out),
  .address_latch_pulse_out(address_latch_pulse_out),
  .data_enable_n_out(data_enable_n_out), .instr_data_status_out(instr_data_status_out),
  .read_write_status_out(read_write_status_out),
  .muxed_addr_data_out(muxed_addr_data_out),
  .muxed_addr_data_oe_out(muxed_addr_data_oe_out), .muxed_parity_out(muxed_parity_out));
`default_nettype wire

// ---- verif/lbc_mem_model.sv ----
// Behavioural expansion memory answering on the local bus
`timescale 1ns/1ps
`default_nettype none
module lbc_mem_model (
  // Bus pins seen by the slave
  input wire logic clk_in,
  input wire logic ale_in,
  input wire logic en_n_in,
  input wire logic rw_in,
  input wire logic clk1_in,
  input wire logic clk2_in,
  input wire logic [15:0] bus_in,
  input wire logic [1:0] par_in,
  // Scenario controls
  input wire logic [1:0] waits_in,
  input wire logic bad_par_in,
  // Slave outputs
  output logic [15:0] rd_out,
  output logic [1:0] rp_out,
  output logic pull_out
);
  logic [17:0] mem [0:16383];
  logic [13:0] adr = 14'h0;
  logic rd_l = 1'b0;
  logic bp_l = 1'b0;
  logic cont = 1'b0;
  logic [1:0] wl = 2'h0;
  assign pull_out = (wl != 2'h0);
  // Latch address and direction as the latch pulse falls; a wait reload is
  // skipped while a cycle continues, or waits would repeat forever
  always @(negedge ale_in)
  begin
    adr <= bus_in[14:1];
    rd_l <= rw_in;
    bp_l <= bad_par_in;
    if (!cont)
      wl <= waits_in;
  end
  // Ready as seen at the start of Q4
  always @(negedge clk2_in) cont <= pull_out;
  // Write capture at phase clock one fall; each fall counts off one wait, ready released when the count reaches zero
  always @(negedge clk1_in)
  begin
    if (wl != 2'h0)
      wl <= wl - 2'h1;
    if (!en_n_in && !rd_l)
      mem[adr] <= {par_in, bus_in};
  end
  // Read data only while enabled, otherwise a toggling pattern
  always @(negedge clk_in)
  begin
    if (!en_n_in && rd_l)
    begin
      rd_out <= mem[adr][15:0];
      rp_out <= mem[adr][17:16] ^ {1'b0, bp_l};
    end
    else
    begin
      rd_out <= ~rd_out;
      rp_out <= ~rp_out;
    end
  end
  initial
  begin
    rd_out = 16'h0;
    rp_out = 2'h0;
  end
endmodule : lbc_mem_model
`default_nettype wire

// ---- verif/tb_lbc_bus_master.sv ----
// Self-checking bench for the local bus cycle engine
`timescale 1ns/1ps
`default_nettype none
module tb_lbc_bus_master;
  import lbc_pkg::*;
  localparam int QC = 2;
  localparam int P = 4 * QC;
  typedef struct packed {logic [15:0] d; logic pe; logic [7:0] w;} lbc_exp_t;
  logic clk_in, rst_n_in, rq_v, rq_w, rq_i, rq_int, role, breq, ireq, bad_par;
  logic [15:0] rq_a, rq_d, rdata, dout, mad, mrd;
  logic [1:0] waits, par_o, mrp, parb;
  logic taken, rsp, perr, oe, ale, en_n, idst, rwst, clk1, clk2, pull, rdy_o, rdy_oe, cwait;
  logic rdy, strch, exp_o;
  logic [31:0] rng;
  logic [7:0] wcnt;
  logic [15:0] shadow [logic [15:0]];
  logic [15:0] adrs [4];
  lbc_exp_t expq [$];
  lbc_exp_t e;
  lbc_exp_t e2;
  int err_count, n_checks;
  // Resolved bus and open-drain ready with pull-up
  assign mad = oe ? dout : mrd;
  assign parb = oe ? par_o : mrp;
  assign rdy = !(pull || (rdy_oe && !rdy_o));
  lbc_bus_master #(.QUARTER_CLKS(QC)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(rq_v), .req_write_in(rq_w), .req_instr_in(rq_i),
    .req_internal_in(rq_int), .req_addr_in(rq_a), .req_wdata_in(rq_d),
    .req_taken_out(taken), .rsp_valid_out(rsp), .rsp_rdata_out(rdata),
    .rsp_parity_err_out(perr), .role_handler_in(role), .slave_selected_in(1'b0),
    .stretch_in(strch), .bus_req_in(breq), .intr_req_in(ireq), .bus_grant_out(),
    .intr_ack_out(), .slave_hold_out(), .ready_low_out(), .cycle_wait_out(cwait),
    .addr_in_expansion_out(exp_o), .phase_clock_one_out(clk1), .phase_clock_two_out(clk2),
    .address_latch_pulse_out(ale), .data_enable_n_out(en_n),
    .instr_data_status_out(idst), .read_write_status_out(rwst),
    .muxed_addr_data_in(mad), .muxed_addr_data_out(dout), .muxed_addr_data_oe_out(oe),
    .muxed_parity_in(parb), .muxed_parity_out(par_o), .local_ready_n_in(rdy),
    .local_ready_n_out(rdy_o), .local_ready_n_oe_out(rdy_oe));
  lbc_mem_model mem_u (.clk_in(clk_in), .ale_in(ale), .en_n_in(en_n), .rw_in(rwst),
    .clk1_in(clk1), .clk2_in(clk2), .bus_in(mad), .par_in(parb), .waits_in(waits),
    .bad_par_in(bad_par), .rd_out(mrd), .rp_out(mrp), .pull_out(pull));
  // Clock at 20 MHz
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // One bus cycle; waits and parity fault are set after the take so that a
  // back-to-back request cannot disturb the cycle already under way
  task automatic cyc(input logic w, ins, intl, h, input logic [15:0] a, wd,
                     input logic [1:0] nw, input logic br, bp);
    int k;
    @(negedge clk_in);
    // A role or bus request is held until the cycles that use it have answered
    while (((role !== h) || (breq === 1'b1)) && (expq.size() > 0))
      @(negedge clk_in);
    rng = xs(rng);
    {rq_v, rq_w, rq_i, rq_int, role, rq_a, rq_d} = {1'b1, w, ins, intl, h, a, wd};
    breq = 1'b0;
    ireq = rng[0];
    for (k = 0; k < 200 && taken !== 1'b1; k++)
      @(negedge clk_in);
    rq_v = 1'b0;
    chk({15'h0, exp_o}, {15'h0, (a >= EXP_LO) && (a <= EXP_HI)});
    breq = br;
    strch = intl;
    waits = nw;
    bad_par = bp;
    e.d = (w || intl) ? 16'h0 : shadow[a];
    e.pe = bp && !w && !intl;
    e.w = h ? 8'h0 : 8'(nw * P);
    expq.push_back(e);
    if (w)
      shadow[a] = wd;
  endtask : cyc
  // Result watcher pairs each response with the oldest expectation
  always @(negedge clk_in)
  begin
    if (!rst_n_in)
      wcnt = 8'h0;
    else
    begin
      if (cwait === 1'b1)
        wcnt = wcnt + 8'h1;
      if (rsp === 1'b1)
      begin
        e2 = (expq.size() > 0) ? expq.pop_front() : '1;
        chk(rdata, e2.d);
        chk({15'h0, perr}, {15'h0, e2.pe});
        chk({8'h0, wcnt}, {8'h0, e2.w});
        wcnt = 8'h0;
      end
    end
  end
  // Watchdog
  initial
  begin
    #(5000 * 50);
    err_count++;
    summarize;
  end
  initial
  begin
    {rq_v, rq_w, rq_i, rq_int, role, breq, ireq, bad_par, strch, rst_n_in} = 10'h0;
    {rq_a, rq_d, waits, wcnt} = 42'h0;
    err_count = 0;
    n_checks = 0;
    rng = 34;
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    // Back-to-back writes then reads to expansion RAM
    for (int i = 0; i < 4; i++)
    begin
      rng = xs(rng);
      adrs[i] = {3'b010, rng[12:1], 1'b0};
      cyc(1, 0, 0, 0, adrs[i], rng[31:16], 0, 0, 0);
    end
    for (int i = 0; i < 4; i++)
      cyc(0, 0, 0, 0, adrs[i], 16'h0, 0, 0, 0);
    // Program store with wait states, bus request raised in mid-cycle
    cyc(1, 0, 0, 0, 16'hE000, 16'hA5C3, 1, 0, 0);
    cyc(0, 1, 0, 0, 16'hE000, 16'h0, 2, 1, 0);
    cyc(0, 1, 0, 1, 16'hE000, 16'h0, 1, 0, 0);
    cyc(0, 0, 0, 0, adrs[0], 16'h0, 0, 0, 0);
    cyc(0, 0, 1, 0, 16'h0200, 16'h0, 0, 0, 0);
    cyc(0, 0, 0, 0, adrs[1], 16'h0, 0, 0, 1);
    repeat (40) @(negedge clk_in);
    chk(16'(expq.size()), 16'h0);
    // Second reset in mid-run shows the data write code
    rst_n_in = 1'b0;
    @(negedge clk_in);
    chk({14'h0, idst, rwst}, {14'h0, STAT_RST});
    chk({15'h0, en_n}, 16'h1);
    summarize;
  end
endmodule : tb_lbc_bus_master
`default_nettype wire
